//--- core/evc_pkg.sv
`default_nettype none

package evc_pkg;

    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned TICK_HZ       = 1;
    localparam int unsigned TICK_CYC      = CLK_HZ / TICK_HZ;
    localparam int unsigned PWM_HZ        = 1_000;
    localparam int unsigned PWM_CYC       = CLK_HZ / PWM_HZ;
    localparam int unsigned PWM_W         = 16;
    localparam logic [PWM_W-1:0] DUTY_RST = 16'h30D4;

    // pilot level classes reported by the sampler
    typedef enum logic [2:0] {
        EVC_LVL_A     = 3'h0,
        EVC_LVL_B     = 3'h1,
        EVC_LVL_C     = 3'h2,
        EVC_LVL_D     = 3'h3,
        EVC_LVL_FAULT = 3'h4
    } evc_lvl_e;

    typedef enum logic [1:0] {
        EVC_RD_INVENTORY,
        EVC_RD_INFO_STATUS,
        EVC_RD_INFO_BLOCKS,
        EVC_RD_DATA
    } evc_rd_e;

    typedef struct packed {
        logic check_failed;
        logic gf_triggered;
        logic relay_stuck;
        logic pilot_fault;
    } evc_fault_s;

    localparam int unsigned FAULT_W = 4;

endpackage : evc_pkg

`default_nettype wire

//--- core/evc_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none

module evc_tick_gen #(
    parameter int unsigned PERIOD = 50_000_000
) (
    input  wire logic clk,    // system clock
    input  wire logic rst,    // sync reset
    output logic      tick    // one-cycle pulse every PERIOD cycles
);
    logic [31:0] cnt_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 32'h0;
            tick  <= 1'b0;
        end else if (cnt_q == 32'(PERIOD - 1)) begin
            cnt_q <= 32'h0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            tick  <= 1'b0;
        end
    end
endmodule : evc_tick_gen

`default_nettype wire

//--- core/evc_pwm.sv
`timescale 1ns/10ps
`default_nettype none

module evc_pwm #(
    parameter int unsigned PERIOD = 50_000,
    parameter int unsigned W      = 16
) (
    input  wire logic         clk,     // system clock
    input  wire logic         rst,     // sync reset
    input  wire logic [W-1:0] duty,    // high cycles per period
    output logic              wave     // free-running waveform
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
            wave  <= 1'b1;
        end else begin
            cnt_q <= (cnt_q == W'(PERIOD - 1)) ? '0 : cnt_q + W'(1);
            wave  <= (cnt_q < duty);
        end
    end
endmodule : evc_pwm

`default_nettype wire

//--- core/evc_session_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module evc_session_ctrl #(
    parameter int unsigned TICK_CYCLES = evc_pkg::TICK_CYC,
    parameter int unsigned PWM_CYCLES  = evc_pkg::PWM_CYC
) (
    input  wire logic                    clk,           // system clock
    input  wire logic                    rst,           // sync reset, also full restart
    input  wire logic                    reader_irq,    // reader new-tag interrupt, async
    input  wire logic                    reader_done,   // reader data read finished, async
    input  wire logic                    card_valid,    // authentication verdict, async
    input  wire logic                    gf_event,      // ground-fault detector, async
    input  wire logic                    relay_fb,      // relay contact feedback, async
    input  wire logic [2:0]              pilot_level,   // pilot_voltage_sampler class, async
    input  wire logic [evc_pkg::PWM_W-1:0] pwm_duty,    // duty from service rating
    output logic                         reader_step,   // one pulse per tick while reading
    output evc_pkg::evc_rd_e             reader_phase,  // current read step
    output logic                         gf_test_coil,  // test coil pulse
    output logic                         pilot_out,     // pilot drive
    output logic                         relay_close,   // charge relay
    output logic                         vent_req,      // venting indicator
    output logic                         fault,         // in fault state
    output evc_pkg::evc_fault_s          fault_cause    // latched fault causes
);
    import evc_pkg::*;

    typedef enum logic [3:0] {
        ST_START, ST_IDLE, ST_CARD, ST_GF_CHECK, ST_GF_EXPECT, ST_GF_PASS,
        ST_A, ST_B, ST_C, ST_D, ST_FAULT
    } evc_state_e;

    evc_state_e state_q;
    evc_state_e state_d;
    logic       tick;
    logic       pwm_wave;
    logic       test_exp_q;
    logic       gf_seen_q;
    logic       pwm_en_q;
    evc_fault_s fault_q;
    logic       duty_cap_q;
    logic [PWM_W-1:0] duty_q;

    // two-flop synchronisers for every asynchronous input
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
        end else begin
            sync1_q <= {pilot_level, relay_fb, gf_event, card_valid, reader_done, reader_irq};
            sync2_q <= sync1_q;
        end
    end
    logic     irq_s, done_s, valid_s, gf_s, relay_s;
    evc_lvl_e lvl_s;
    assign irq_s   = sync2_q[0];
    assign done_s  = sync2_q[1];
    assign valid_s = sync2_q[2];
    assign gf_s    = sync2_q[3];
    assign relay_s = sync2_q[4];
    assign lvl_s   = evc_lvl_e'(sync2_q[7:5]);

    logic gf_s_q;
    always_ff @(posedge clk) begin
        if (rst) gf_s_q <= 1'b0;
        else gf_s_q <= gf_s;
    end
    logic gf_rise;
    assign gf_rise = gf_s & ~gf_s_q;

    evc_tick_gen #(.PERIOD(TICK_CYCLES)) u_tick (
        .clk  (clk),
        .rst  (rst),
        .tick (tick)
    );

    // duty caught once after reset, then held for the whole session
    always_ff @(posedge clk) begin
        if (rst) begin
            duty_cap_q <= 1'b0;
            duty_q     <= DUTY_RST;
        end else if (!duty_cap_q) begin
            duty_cap_q <= 1'b1;
            duty_q     <= pwm_duty;
        end
    end

    evc_pwm #(.PERIOD(PWM_CYCLES), .W(PWM_W)) u_pwm (
        .clk  (clk),
        .rst  (rst),
        .duty (duty_q),
        .wave (pwm_wave)
    );

    // next state, evaluated only on the tick
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_START:     state_d = ST_IDLE;
            ST_IDLE:      if (irq_s) state_d = ST_CARD;
            ST_CARD: begin
                if (done_s) state_d = valid_s ? ST_GF_CHECK : ST_IDLE;
            end
            ST_GF_CHECK:  state_d = ST_GF_EXPECT;
            ST_GF_EXPECT: state_d = gf_seen_q ? ST_GF_PASS : ST_FAULT;
            ST_GF_PASS:   state_d = ST_A;
            ST_A: begin
                if (lvl_s == EVC_LVL_B) state_d = ST_B;
                else if (lvl_s != EVC_LVL_A) state_d = ST_FAULT;
            end
            ST_B: begin
                case (lvl_s)
                    EVC_LVL_C:     state_d = ST_C;
                    EVC_LVL_A:     state_d = ST_A;
                    EVC_LVL_FAULT: state_d = ST_FAULT;
                    default:       state_d = ST_B;
                endcase
            end
            ST_C: begin
                case (lvl_s)
                    EVC_LVL_B:     state_d = ST_B;
                    EVC_LVL_A:     state_d = ST_A;
                    EVC_LVL_D:     state_d = ST_D;
                    EVC_LVL_FAULT: state_d = ST_FAULT;
                    default:       state_d = ST_C;
                endcase
            end
            ST_D: begin
                if (lvl_s == EVC_LVL_C) state_d = ST_C;
                else if (lvl_s == EVC_LVL_FAULT) state_d = ST_FAULT;
            end
            ST_FAULT:     state_d = ST_FAULT;
            default:      state_d = ST_FAULT;
        endcase
        // asynchronous-cause faults override any pending move
        if (state_q != ST_FAULT && (|fault_q)) state_d = ST_FAULT;
    end

    always_ff @(posedge clk) begin
        if (rst) state_q <= ST_START;
        else if (tick) state_q <= state_d;
    end

    logic entering;
    assign entering = tick && (state_d != state_q);

    // test-expected flag set on entry to the check, coil pulse on the next tick, as the check is left
    always_ff @(posedge clk) begin
        if (rst) begin
            test_exp_q   <= 1'b0;
            gf_test_coil <= 1'b0;
        end else begin
            gf_test_coil <= 1'b0;
            if (entering && state_d == ST_GF_CHECK) test_exp_q <= 1'b1;
            else if (tick && state_q == ST_GF_EXPECT) test_exp_q <= 1'b0;
            if (tick && state_q == ST_GF_CHECK) gf_test_coil <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) gf_seen_q <= 1'b0;
        else if (test_exp_q && gf_rise) gf_seen_q <= 1'b1;
        else if (entering && state_d == ST_GF_CHECK) gf_seen_q <= 1'b0;
    end

    // fault causes are sticky; only rst clears them
    always_ff @(posedge clk) begin
        if (rst) begin
            fault_q <= '0;
        end else begin
            if (gf_rise && !test_exp_q) fault_q.gf_triggered <= 1'b1;
            if (tick && state_q == ST_GF_EXPECT && !gf_seen_q) fault_q.check_failed <= 1'b1;
            if (tick && (state_q inside {ST_A, ST_B, ST_C, ST_D}) && state_d == ST_FAULT
                && !(|fault_q)) fault_q.pilot_fault <= 1'b1;
            // contacts must follow the command once the relay has had a tick to move
            if (tick && relay_s != relay_close && state_q != ST_FAULT)
                fault_q.relay_stuck <= 1'b1;
        end
    end

    // outputs registered from state
    always_ff @(posedge clk) begin
        if (rst) begin
            pwm_en_q    <= 1'b0;
            relay_close <= 1'b0;
            vent_req    <= 1'b0;
            fault       <= 1'b0;
        end else begin
            pwm_en_q    <= state_q inside {ST_B, ST_C, ST_D};
            relay_close <= state_q inside {ST_C, ST_D};
            vent_req    <= (state_q == ST_D);
            fault       <= (state_q == ST_FAULT);
        end
    end

    // static high outside PWM states, including fault
    always_ff @(posedge clk) begin
        if (rst) pilot_out <= 1'b1;
        else pilot_out <= pwm_en_q ? pwm_wave : 1'b1;
    end

    assign fault_cause = fault_q;

    // reader stepping: one call per tick while in card check
    always_ff @(posedge clk) begin
        if (rst) begin
            reader_step  <= 1'b0;
            reader_phase <= EVC_RD_INVENTORY;
        end else begin
            reader_step <= tick && state_q == ST_CARD;
            if (tick && state_q == ST_CARD) begin
                if (reader_phase != EVC_RD_DATA)
                    reader_phase <= evc_rd_e'(reader_phase + 2'h1);
            end else if (state_q != ST_CARD) begin
                reader_phase <= EVC_RD_INVENTORY;
            end
        end
    end

    a_fault_sticky: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_FAULT |=> state_q == ST_FAULT)
        else $error("left fault state");

    a_fault_safe: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_FAULT ##2 state_q == ST_FAULT |-> !relay_close && pilot_out)
        else $error("fault state not safe");

    a_tick_only: assert property (@(posedge clk) disable iff (rst)
        !tick |=> $stable(state_q))
        else $error("state moved off tick");

    a_gf_masked: assert property (@(posedge clk) disable iff (rst)
        test_exp_q && gf_rise |=> $stable(fault_q.gf_triggered))
        else $error("masked ground fault raised");

    a_coil_after_flag: assert property (@(posedge clk) disable iff (rst)
        gf_test_coil |-> test_exp_q)
        else $error("coil pulse without test flag");

    a_relay_in_c: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_C && $past(state_q) == ST_C |-> relay_close)
        else $error("relay open in state C");

    a_static_in_a: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_A ##3 state_q == ST_A |-> pilot_out)
        else $error("pilot not static in state A");

    a_d_exits: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_D ##1 state_q != ST_D |-> state_q inside {ST_C, ST_FAULT})
        else $error("illegal exit from state D");

    a_card_path: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_GF_CHECK |-> $past(state_q) inside {ST_CARD, ST_GF_CHECK})
        else $error("self test without card");

    a_step_in_card: assert property (@(posedge clk) disable iff (rst)
        reader_step |-> $past(state_q) == ST_CARD)
        else $error("reader step outside card check");

    a_step_pulse: assert property (@(posedge clk) disable iff (rst)
        reader_step |=> !reader_step)
        else $error("reader step longer than one cycle");

    a_phase_idle: assert property (@(posedge clk) disable iff (rst)
        state_q != ST_CARD && $past(state_q) != ST_CARD
            |-> reader_phase == EVC_RD_INVENTORY)
        else $error("read phase not parked");

    a_phase_order: assert property (@(posedge clk) disable iff (rst)
        $changed(reader_phase) && reader_phase != EVC_RD_INVENTORY
            |-> reader_phase == evc_rd_e'($past(reader_phase) + 2'h1))
        else $error("read phase out of order");

    a_coil_pulse: assert property (@(posedge clk) disable iff (rst)
        gf_test_coil |=> !gf_test_coil)
        else $error("coil pulse longer than one cycle");

    a_coil_from_check: assert property (@(posedge clk) disable iff (rst)
        gf_test_coil |-> state_q inside {ST_GF_EXPECT, ST_FAULT})
        else $error("coil pulse outside self test");

    a_pass_needs_seen: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_GF_PASS && $past(state_q) == ST_GF_EXPECT |-> $past(gf_seen_q))
        else $error("self test passed without detector");

    a_check_fail: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_GF_EXPECT && tick && !gf_seen_q |=> fault_q.check_failed)
        else $error("missed self test not flagged");

    a_vent_only_d: assert property (@(posedge clk) disable iff (rst)
        vent_req |-> $past(state_q) == ST_D)
        else $error("venting shown outside state D");

    a_relay_states: assert property (@(posedge clk) disable iff (rst)
        relay_close |-> $past(state_q) inside {ST_C, ST_D})
        else $error("relay closed outside C or D");

    a_pwm_states: assert property (@(posedge clk) disable iff (rst)
        pwm_en_q |-> $past(state_q) inside {ST_B, ST_C, ST_D})
        else $error("pwm enabled outside B, C or D");

    a_fault_out: assert property (@(posedge clk) disable iff (rst)
        fault == ($past(state_q) == ST_FAULT))
        else $error("fault output does not follow state");

    a_idle_hold: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_IDLE && tick && !irq_s && !(|fault_q) |=> state_q == ST_IDLE)
        else $error("left idle without a card");

    a_cause_sticky: assert property (@(posedge clk) disable iff (rst)
        (fault_q | $past(fault_q)) == fault_q)
        else $error("fault cause cleared");

    a_a_exit: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_B && $past(state_q) == ST_A |-> $past(lvl_s) == EVC_LVL_B)
        else $error("state B entered without level drop");

    a_c_entry: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_C && $past(state_q) == ST_B |-> $past(lvl_s) == EVC_LVL_C)
        else $error("state C entered without ready level");

endmodule : evc_session_ctrl

`default_nettype wire

//--- tb/evc_far_model.sv
`timescale 1ns/10ps
`default_nettype none

// vehicle on the pilot line, relay contacts, fault detector and card reader
module evc_far_model (
    input  wire logic       clk,          // system clock
    input  wire logic       rst,          // sync reset
    input  wire logic [2:0] lvl_set,      // pilot class the vehicle shows
    input  wire logic       card_in,      // tag held at the reader
    input  wire logic       card_good,    // tag content authenticates
    input  wire logic       gf_answer,    // detector answers the coil
    input  wire logic       gf_stray,     // detector fires on its own
    input  wire logic       relay_weld,   // contacts do not follow
    input  wire logic       reader_step,  // reader step request
    input  wire logic       gf_test_coil, // test coil pulse
    input  wire logic       relay_close,  // relay command
    output logic            reader_irq,   // new tag interrupt
    output logic            reader_done,  // read complete
    output logic            card_valid,   // verdict
    output logic            gf_event,     // detector output
    output logic            relay_fb,     // contact feedback
    output logic [2:0]      pilot_level   // sampler class
);
    // only vicinity cards at this rate; other tags need another setup
    localparam int unsigned RD_KBPS = 48;
    logic [2:0] steps_q;
    logic [1:0] coil_q;
    logic       fb_q;

    initial begin
        {reader_irq, reader_done, card_valid, gf_event, relay_fb} = 5'h00;
        pilot_level = 3'h0;
    end

    always @(posedge clk) begin
        if (rst || !card_in) begin
            steps_q <= 3'h0;
        end else if (reader_step && steps_q != 3'h4) begin
            steps_q <= steps_q + 3'h1;
        end
        coil_q <= {coil_q[0], gf_test_coil};
        fb_q   <= relay_close;
    end

    // the interrupt drops once the tag is read, so a read tag is not seen as new
    always @(posedge clk) begin
        reader_irq  <= #1 card_in && steps_q != 3'h4;
        reader_done <= #1 steps_q == 3'h4;
        card_valid  <= #1 card_good ~^ (steps_q == 3'h4);
        gf_event    <= #1 gf_stray | (gf_answer & (coil_q != 2'h0));
        relay_fb    <= #1 relay_weld ? 1'b0 : fb_q;
        pilot_level <= #1 lvl_set;
    end
endmodule : evc_far_model

`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import evc_pkg::*;
    localparam int unsigned TK = 20; // short tick for sim
    localparam int unsigned PW = 10; // short pwm period for sim
    localparam logic [PWM_W-1:0] DUTY = 16'h0004;
    logic             clk, rst, card_in, card_good, gf_answer, gf_stray, relay_weld;
    logic [2:0]       lvl_set, pilot_level;
    logic             reader_irq, reader_done, card_valid, gf_event, relay_fb;
    logic             reader_step, gf_test_coil, pilot_out, relay_close, vent_req, fault;
    evc_rd_e          reader_phase, ph_last;
    evc_fault_s       fault_cause;
    int               n_mismatch, compares, n_coil;
    logic [1:0]       ph_log[$];

    evc_session_ctrl #(.TICK_CYCLES(TK), .PWM_CYCLES(PW)) uut (
        .clk, .rst, .reader_irq, .reader_done, .card_valid, .gf_event, .relay_fb,
        .pilot_level, .pwm_duty(DUTY), .reader_step, .reader_phase, .gf_test_coil,
        .pilot_out, .relay_close, .vent_req, .fault, .fault_cause);

    evc_far_model far (
        .clk, .rst, .lvl_set, .card_in, .card_good, .gf_answer, .gf_stray,
        .relay_weld, .reader_step, .gf_test_coil, .relay_close, .reader_irq,
        .reader_done, .card_valid, .gf_event, .relay_fb, .pilot_level);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        if (gf_test_coil === 1'b1) n_coil++;
        if (!rst && reader_phase !== ph_last) ph_log.push_back(reader_phase);
        ph_last = reader_phase;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic ticks(input int n);
        repeat (n * TK) @(posedge clk);
        #1;
    endtask : ticks

    // pilot highs over two pwm periods: 2*PW when static, 2*DUTY when modulated
    task automatic highs(output int h);
        h = 0;
        repeat (2 * PW) begin
            @(posedge clk);
            h += int'(pilot_out === 1'b1);
        end
        #1;
    endtask : highs

    task automatic do_reset;
        rst = 1'b1;
        {card_in, card_good, gf_answer, gf_stray, relay_weld} = 5'h00;
        lvl_set = 3'h0;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        ticks(2);
    endtask : do_reset

    task automatic to_a(input logic ok);
        gf_answer = ok;
        card_good = 1'b1;
        card_in = 1'b1;
        ticks(8);
        card_in = 1'b0;
        ticks(2);
    endtask : to_a

    task automatic s_idle;
        n_coil = 0;
        ph_log.delete();
        do_reset();
        check("pilot", pilot_out, 1);
        check("out", {relay_close, vent_req, fault, fault_cause, reader_phase}, 0);
        ticks(3);
        check("idle", n_coil + int'(reader_phase), 0);
        card_in = 1'b1;
        ticks(9);
        check("nlog", ph_log.size(), 4);
        check("log", {ph_log[0], ph_log[1], ph_log[2], ph_log[3]}, 8'h6C);
        check("bad", n_coil, 0);
        check("badst", {fault, relay_close}, 0);
        card_in = 1'b0;
    endtask : s_idle

    task automatic s_good;
        int h;
        n_coil = 0;
        do_reset();
        to_a(1'b1);
        check("coil", n_coil, 1);
        check("pass", {fault, relay_close}, 0);
        highs(h);
        check("a", h, 2 * PW);
        lvl_set = 3'h1;
        ticks(2);
        highs(h);
        check("b", h, 2 * DUTY);
        check("brel", relay_close, 0);
        lvl_set = 3'h2;
        ticks(2);
        check("c", relay_close, 1);
        lvl_set = 3'h3;
        ticks(2);
        check("d", {vent_req, relay_close}, 2'h3);
        lvl_set = 3'h1;
        ticks(2);
        check("dhold", vent_req, 1);
        lvl_set = 3'h2;
        ticks(2);
        check("dc", {vent_req, relay_close}, 2'h1);
        lvl_set = 3'h1;
        ticks(2);
        check("cb", relay_close, 0);
        lvl_set = 3'h0;
        ticks(2);
        highs(h);
        check("ba", h, 2 * PW);
    endtask : s_good

    task automatic s_fault(input int k, input logic [3:0] exp);
        int h;
        do_reset();
        gf_stray = (k == 1);
        ticks(1);
        gf_stray = 1'b0;
        if (k != 1) to_a(k != 0);
        if (k == 2) lvl_set = 3'h3;
        if (k >= 3) lvl_set = 3'h1;
        relay_weld = (k == 3);
        ticks(2);
        if (k == 3) lvl_set = 3'h2;
        if (k == 4) lvl_set = 3'h4;
        // a welded relay needs a tick to enter C, one to be caught, one to reach fault
        ticks(4);
        check("fault", fault, 1);
        check("cause", fault_cause, exp);
        check("safe", relay_close, 0);
        lvl_set = 3'h2;
        card_in = 1'b1;
        ticks(3);
        highs(h);
        check("hold", fault, 1);
        check("static", h, 2 * PW);
    endtask : s_fault

    task automatic finish_test;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        {card_in, card_good, gf_answer, gf_stray, relay_weld} = 5'h00;
        lvl_set = 3'h0;
        s_idle();
        s_good();
        s_fault(0, 4'h8);
        s_fault(1, 4'h4);
        s_fault(2, 4'h1);
        s_fault(3, 4'h2);
        s_fault(4, 4'h1);
        finish_test();
    end
endmodule : tb_top

`default_nettype wire
